// ---- common/adc_readout_params.svh ----
// Purpose: constants for the serial conversion readout block
// Assumes: included by its bare name from the design files
// Notes:   widths and counts are fixed; the package holds the types
//
// Behaviour
// - select low runs, select high powers down
// - select falling edge starts new conversion
// - frame: four nulls, twelve bits, MSB first
// - output changes on falling clock, host samples rising
// - result is twelve-bit two's complement difference
// - serial clock shifts data and times conversion
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define DATA_BITS       12
`define NULL_BITS       4
`define FRAME_BITS      16
`define FRAME_LAST      4'hf
`define NULL_LAST       4'h3
`define CNT_RESET       4'h0
`define WORD_RESET      12'h000
`define SHIFT_RESET     16'h0000

// ****************************************************************
// buffering and timing
// ****************************************************************
`define FIFO_DEPTH      16
`define CLK_PERIOD_NS   10
`define SCLK_MAX_MHZ    16
`define SCLK_MIN_MHZ    8

`endif

// ---- common/adc_readout_pkg.sv ----
// Purpose: types shared by the serial conversion readout block
// Assumes: nothing imported; users write adc_readout_pkg::name
// Notes:   state codes are gray along power-down, shift, hold
package adc_readout_pkg;

	// ****************************************************************
	// conversion sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		POWER_DOWN = 2'b00, // select high, output floating
		SHIFTING   = 2'b01, // frame in progress
		HOLDING    = 2'b11  // frame complete, waiting for select high
	} conv_state_t;

endpackage

// ---- dv/host_serial_model.sv ----
// Purpose: host serial controller that frames conversions and reads them
// Assumes: serial clock idles low and stands still between frames unless stray is called
// Notes:   timing is by delays, 3 ns off the system clock grid; select release lands 8 ns off it
`timescale 1ns/1ps

module host_serial_model (
	output logic      cs_n,      // conversion select, active low
	output logic      sclk,      // serial clock, 80 ns period
	input  wire logic dout,      // serial data from the device
	input  wire logic dout_oe_n  // device output enable, low
);
	// ****************************************************************
	// idle levels
	// ****************************************************************
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end

	// one frame; low 50 ns then high 30 ns keeps 80 ns but leaves the
	// device its full sync latency before each sampling edge
	task automatic frame(input int ncyc, input int lead,
		output logic [15:0] word, output logic float_seen);
		word = 16'h0000;
		float_seen = 1'b0;
		#3;
		cs_n = 1'b0;
		#(lead);
		for (int i = 0; i < ncyc; i++) begin
			#50;
			sclk = 1'b1;
			if (i < 16) begin
				word = {word[14:0], dout};
			end
			float_seen = float_seen | (dout_oe_n !== 1'b0);
			#30;
			sclk = 1'b0;
		end
	endtask

	// end of frame: select back high
	task automatic release_sel();
		#25;
		cs_n = 1'b1;
	endtask

	// stray clocks with select high, only when a test asks for them
	task automatic stray(input int n);
		#3; // keep the pin edges off the sampling clock edge
		repeat (n) begin
			#40;
			sclk = 1'b1;
			#40;
			sclk = 1'b0;
		end
	endtask
endmodule

// ---- dv/test_adc_serial_readout.sv ----
// Purpose: self-checking bench for the serial conversion readout block
// Assumes: host model drives select and serial clock
// Notes:   integer queue model predicts every frame and status
`timescale 1ns/1ps
`include "adc_readout_params.svh"

module test_adc_serial_readout;
	logic                  clk;          // system clock
	logic                  rst;          // reset, active high
	logic                  cs_n;         // select from host
	logic                  sclk;         // serial clock from host
	logic                  dout;         // serial data
	logic                  dout_oe_n;    // output enable, low
	logic                  dout_line;    // data line as the host sees it
	logic [`DATA_BITS-1:0] sample_data;  // word offered
	logic                  sample_valid; // word offered flag
	logic                  sample_ready; // room in buffer
	logic                  power_down;   // power-down flag
	logic                  conv_busy;    // frame running
	logic                  underrun;     // stale word reused
	int                    err_total;    // mismatches
	int                    cmp_count;    // comparisons
	int                    q[$];         // words expected in buffer
	int                    last_w;       // word of previous frame

	// ****************************************************************
	// instances and clock
	// ****************************************************************
	adc_serial_readout dut (.clk(clk), .rst(rst), .cs_n(cs_n),
		.sclk(sclk), .dout(dout), .dout_oe_n(dout_oe_n),
		.sample_data(sample_data), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .power_down(power_down),
		.conv_busy(conv_busy), .underrun(underrun));
	// no pull on the line: a floating output reads as the inverse of the
	// held bit, so a sample taken while floating cannot pass by luck
	assign dout_line = dout_oe_n ? !dout : dout;
	host_serial_model host (.cs_n(cs_n), .sclk(sclk), .dout(dout_line),
		.dout_oe_n(dout_oe_n));

	always #5 clk = ~clk;

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic finish_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// status packed as oe_n, power_down, busy, underrun
	task automatic status(input logic [3:0] exp);
		check("status", {12'h000, exp},
			{12'h000, dout_oe_n, power_down, conv_busy, underrun});
	endtask

	// offer one word from a rising edge; bounded wait for ready
	task automatic push(input logic [11:0] w);
		int n;
		n = 0;
		sample_data <= w;
		sample_valid <= 1'b1;
		@(negedge clk);
		while (sample_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk);
		end
		if (sample_ready !== 1'b1) begin
			err_total++;
			$display("mismatch sample_ready expected 1 seen 0");
			finish_test();
		end
		@(posedge clk);
		q.push_back(w);
	endtask

	// one conversion frame, judged against the queue model
	task automatic do_frame(input int ncyc, input int lead);
		logic [15:0] w;
		logic        fl;
		logic        und;
		und = (q.size() == 0);
		if (!und) begin
			last_w = q.pop_front();
		end
		host.frame(ncyc, lead, w, fl);
		if (ncyc >= 16) begin
			check("frame", {4'h0, last_w[11:0]}, w);
		end
		check("float", 16'h0000, {15'h0000, fl});
		#60;
		status({1'b0, 1'b0, ncyc < 16, und});
		host.release_sel();
		#60;
		status({1'b1, 1'b1, 1'b0, und});
		@(posedge clk);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		sample_data = 12'h000;
		sample_valid = 1'b0;
		err_total = 0;
		cmp_count = 0;
		last_w = 0;
		void'($urandom(9056));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		status(4'hc);
		@(posedge clk);
		// boundary codes, prompt and slow host
		push(12'h800);
		push(12'h7ff);
		push(12'hfff);
		push(12'h001);
		sample_valid <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			do_frame(16, (i == 3) ? 400 : 0);
		end
		// stray clocks with select high change nothing
		host.stray(3);
		status(4'hc);
		// fill until refused, then drain with abort and overrun clocks
		@(posedge clk);
		for (int i = 0; i < `FIFO_DEPTH; i++) begin
			push(12'($urandom()));
		end
		sample_valid <= 1'b0;
		@(negedge clk);
		check("full", 16'h0000, {15'h0000, sample_ready});
		@(posedge clk);
		do_frame(5, 0);
		for (int i = 0; i < `FIFO_DEPTH; i++) begin
			do_frame((i == 14) ? 20 : 16, 0);
		end
		check("empty", 16'h0001, {15'h0000, sample_ready});
		// fresh word clears the stale flag
		push(12'($urandom()));
		sample_valid <= 1'b0;
		do_frame(16, 0);
		finish_test();
	end
endmodule

// ---- rtl/adc_serial_readout.sv ----
// Purpose: device-side serial readout and conversion sequencer
// Assumes: select and serial clock are pins, sampled by clk (100 MHz)
// Notes:   samples arrive through a FIFO and are taken at frame start
`timescale 1ns/1ps
`include "adc_readout_params.svh"

module adc_serial_readout (
	input  wire logic                  clk,          // system clock
	input  wire logic                  rst,          // async reset, high
	input  wire logic                  cs_n,         // conversion select pin
	input  wire logic                  sclk,         // serial clock pin
	output logic                       dout,         // serial data out
	output logic                       dout_oe_n,    // output enable, low
	input  wire logic [`DATA_BITS-1:0] sample_data,  // signed difference
	input  wire logic                  sample_valid, // sample offered
	output logic                       sample_ready, // FIFO has room
	output logic                       power_down,   // power-down mode
	output logic                       conv_busy,    // frame in progress
	output logic                       underrun      // last frame had no
	                                                 // fresh sample
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic                  cs_n_meta_q;   // first sync stage
	logic                  cs_n_sync_q;   // second sync stage
	logic                  cs_n_prev_q;   // delayed for edge detect
	logic                  sclk_meta_q;   // first sync stage
	logic                  sclk_sync_q;   // second sync stage
	logic                  sclk_prev_q;   // delayed for edge detect
	logic                  cs_fall;       // select went low
	logic                  sclk_fall;     // serial clock fell
	logic                  active;        // select held low
	adc_readout_pkg::conv_state_t state_q; // sequencer state
	adc_readout_pkg::conv_state_t state_d; // next state
	logic [3:0]            bit_cnt_q;     // index of bit on the line
	logic [`DATA_BITS-1:0] word_q;        // sample being converted
	logic [`FRAME_BITS-1:0] shift_q;      // outgoing frame
	logic                  dout_q;        // registered data pin
	logic                  dout_oe_n_q;   // registered enable pin
	logic                  power_down_q;  // registered mode flag
	logic                  underrun_q;    // stale sample flag
	logic [`DATA_BITS-1:0] fifo_data;     // FIFO head word
	logic                  fifo_valid;    // FIFO not empty
	logic                  fifo_take;     // pop at frame start
	logic [`DATA_BITS-1:0] next_word;     // word for the new frame

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// select pin: two stages before any logic looks at it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_n_meta_q <= 1'b1;
			cs_n_sync_q <= 1'b1;
			cs_n_prev_q <= 1'b1;
		end else begin
			cs_n_meta_q <= cs_n;
			cs_n_sync_q <= cs_n_meta_q;
			cs_n_prev_q <= cs_n_sync_q;
		end
	end

	// serial clock pin: sampled, at 16 MHz that gives six samples a period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_meta_q <= 1'b0;
			sclk_sync_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_meta_q <= sclk;
			sclk_sync_q <= sclk_meta_q;
			sclk_prev_q <= sclk_sync_q;
		end
	end

	// edges are taken from the second stage and its delayed copy only
	assign cs_fall   = cs_n_prev_q && !cs_n_sync_q;
	assign sclk_fall = sclk_prev_q && !sclk_sync_q;
	assign active    = !cs_n_sync_q;

	// ****************************************************************
	// sample buffer
	// ****************************************************************
	// the front end is held off when all sixteen words are waiting
	sample_fifo #(
		.WIDTH (`DATA_BITS),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_take)
	);

	// one word per frame; drained only at conversion start
	assign fifo_take = cs_fall;
	// with no fresh word the previous sample is converted again
	assign next_word = fifo_valid ? fifo_data : word_q;

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// next state; a new fall of select restarts from any state
	always_comb begin
		state_d = state_q;
		case (state_q)
			adc_readout_pkg::POWER_DOWN: begin
				if (cs_fall) begin
					state_d = adc_readout_pkg::SHIFTING;
				end
			end
			adc_readout_pkg::SHIFTING: begin
				if (!active) begin
					// frame aborted early, back to power-down
					state_d = adc_readout_pkg::POWER_DOWN;
				end else if (sclk_fall && bit_cnt_q == `FRAME_LAST) begin
					state_d = adc_readout_pkg::HOLDING;
				end
			end
			adc_readout_pkg::HOLDING: begin
				if (!active) begin
					state_d = adc_readout_pkg::POWER_DOWN;
				end
			end
			default: begin
				state_d = adc_readout_pkg::POWER_DOWN;
			end
		endcase
		if (cs_fall) begin
			state_d = adc_readout_pkg::SHIFTING;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= adc_readout_pkg::POWER_DOWN;
		end else begin
			state_q <= state_d;
		end
	end

	// bit index: the serial clock is the only conversion timebase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt_q <= `CNT_RESET;
		end else if (cs_fall) begin
			bit_cnt_q <= `CNT_RESET;
		end else if (state_q == adc_readout_pkg::SHIFTING && sclk_fall &&
			bit_cnt_q != `FRAME_LAST) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// sample capture at conversion start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_q <= `WORD_RESET;
		end else if (cs_fall) begin
			word_q <= next_word;
		end
	end

	// stale-sample flag, refreshed each frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			underrun_q <= 1'b0;
		end else if (cs_fall) begin
			underrun_q <= !fifo_valid;
		end
	end

	// ****************************************************************
	// serial output
	// ****************************************************************
	// frame is nulls then the two's-complement word, MSB first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_q <= `SHIFT_RESET;
		end else if (cs_fall) begin
			shift_q <= {{`NULL_BITS{1'b0}}, next_word};
		end else if (state_q == adc_readout_pkg::SHIFTING && active &&
			sclk_fall) begin
			shift_q <= {shift_q[`FRAME_BITS-2:0], 1'b0};
		end
	end

	// data pin: first null appears at select fall, next bits on sclk falls;
	// past the last bit the line reads zero; value held while floating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout_q <= 1'b0;
		end else if (cs_fall) begin
			dout_q <= 1'b0;
		end else if (state_q == adc_readout_pkg::SHIFTING && active &&
			sclk_fall) begin
			dout_q <= shift_q[`FRAME_BITS-2];
		end
	end

	// enable pin is active low; the line floats whenever select is high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout_oe_n_q <= 1'b1;
		end else begin
			dout_oe_n_q <= cs_n_sync_q;
		end
	end

	// power-down follows select directly
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_down_q <= 1'b1;
		end else begin
			power_down_q <= cs_n_sync_q;
		end
	end

	assign dout       = dout_q;
	assign dout_oe_n  = dout_oe_n_q;
	assign power_down = power_down_q;
	assign conv_busy  = (state_q == adc_readout_pkg::SHIFTING);
	assign underrun   = underrun_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	AST_PD_MODE: assert property (
		@(posedge clk) disable iff (rst)
		$rose(cs_n_sync_q) |=> power_down_q &&
			state_q == adc_readout_pkg::POWER_DOWN)
		else $error("select high did not enter power-down");

	AST_START: assert property (
		@(posedge clk) disable iff (rst)
		cs_fall |=> state_q == adc_readout_pkg::SHIFTING &&
			bit_cnt_q == `CNT_RESET && !power_down_q)
		else $error("select fall did not start a conversion");

	AST_NULLS: assert property (
		@(posedge clk) disable iff (rst)
		(state_q == adc_readout_pkg::SHIFTING &&
			bit_cnt_q <= `NULL_LAST) |-> !dout_q)
		else $error("null bit not zero");

	AST_MSB: assert property (
		@(posedge clk) disable iff (rst)
		(state_q == adc_readout_pkg::SHIFTING && active && !cs_fall &&
			sclk_fall && bit_cnt_q == `NULL_LAST) |=>
			dout_q == word_q[`DATA_BITS-1])
		else $error("sign bit not first after nulls");

	AST_FALL_ONLY: assert property (
		@(posedge clk) disable iff (rst)
		(!sclk_fall && !cs_fall) |=> $stable(dout_q))
		else $error("data changed without a falling clock");

	AST_COUNT: assert property (
		@(posedge clk) disable iff (rst)
		(state_q == adc_readout_pkg::SHIFTING && !cs_fall && sclk_fall &&
			bit_cnt_q != `FRAME_LAST) |=>
			bit_cnt_q == $past(bit_cnt_q) + 4'h1)
		else $error("bit index did not follow serial clock");

	AST_DONE: assert property (
		@(posedge clk) disable iff (rst)
		(state_q == adc_readout_pkg::SHIFTING && active && !cs_fall &&
			sclk_fall && bit_cnt_q == `FRAME_LAST) |=>
			state_q == adc_readout_pkg::HOLDING)
		else $error("frame did not end after sixteen bits");

	AST_HIZ: assert property (
		@(posedge clk) disable iff (rst)
		cs_n_sync_q |=> dout_oe_n_q)
		else $error("output driven while select high");

endmodule

// ---- rtl/sample_fifo.sv ----
// Purpose: small synchronous FIFO for converted sample words
// Assumes: single clock, asynchronous active-high reset
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
`include "adc_readout_params.svh"

module sample_fifo #(
	parameter int WIDTH = `DATA_BITS,  // word width
	parameter int DEPTH = `FIFO_DEPTH  // number of words
) (
	input  wire logic             clk,       // system clock
	input  wire logic             rst,       // async reset, active high
	input  wire logic [WIDTH-1:0] in_data,   // word to store
	input  wire logic             in_valid,  // in_data is offered
	output logic                  in_ready,  // room for a word
	output logic      [WIDTH-1:0] out_data,  // oldest word
	output logic                  out_valid, // a word is stored
	input  wire logic             out_ready  // consumer takes the word
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // storage array
	logic [AW:0]      wr_ptr_q;      // write pointer with wrap bit
	logic [AW:0]      rd_ptr_q;      // read pointer with wrap bit
	logic             push;          // word accepted this cycle
	logic             pop;           // word removed this cycle

	// ****************************************************************
	// flags
	// ****************************************************************
	// full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
		(wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
	assign out_valid = (wr_ptr_q != rd_ptr_q);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_q[AW-1:0]];

	// storage write; no reset needed, valid words are tracked by pointers
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q[AW-1:0]] <= in_data;
		end
	end

	// write pointer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
		end else if (push) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	// read pointer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_ptr_q <= '0;
		end else if (pop) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

endmodule
